// ==== pkg/crp_pkg.sv ====
package crp_pkg;

    // Register map of the system register window
    localparam logic [7:0] CRP_ADDR_TBL_HI = 8'h82;
    localparam logic [7:0] CRP_ADDR_PTR_LO = 8'h83;
    localparam logic [7:0] CRP_ADDR_PTR_HI = 8'h84;
    localparam logic [7:0] CRP_ADDR_STATUS = 8'h86;
    localparam logic [7:0] CRP_ADDR_PC_LOW = 8'hCE;
    localparam logic [7:0] CRP_ADDR_PC_HIGH = 8'hCF;

    // Status field positions
    localparam int CRP_FLAG_Z = 0;
    localparam int CRP_FLAG_DC = 1;
    localparam int CRP_FLAG_C = 2;
    localparam int CRP_FLAG_MID = 4;
    localparam int CRP_FLAG_HIGH = 5;
    localparam int CRP_CAUSE_LO = 6;
    localparam int CRP_CAUSE_HI = 7;

    // Reset values and fixed steps
    localparam logic [9:0] CRP_PC_RESET = 10'h000;
    localparam logic [7:0] CRP_REG_RESET = 8'h00;
    localparam logic [9:0] CRP_PC_STEP = 10'h001;
    localparam logic [9:0] CRP_PC_SKIP = 10'h002;
    localparam logic [7:0] CRP_ONE = 8'h01;

    // Reset cause codes
    localparam logic [1:0] CRP_CAUSE_WDT = 2'h0;
    localparam logic [1:0] CRP_CAUSE_RSVD = 2'h1;
    localparam logic [1:0] CRP_CAUSE_LVD = 2'h2;
    localparam logic [1:0] CRP_CAUSE_PIN = 2'h3;

    typedef enum logic [4:0] {
        CRP_OP_NOP = 5'h00,
        CRP_OP_MOV_A_IMM = 5'h01,
        CRP_OP_ADD = 5'h02,
        CRP_OP_ADC = 5'h03,
        CRP_OP_SUB = 5'h04,
        CRP_OP_SBC = 5'h05,
        CRP_OP_AND = 5'h06,
        CRP_OP_OR = 5'h07,
        CRP_OP_XOR = 5'h08,
        CRP_OP_RLC = 5'h09,
        CRP_OP_RRC = 5'h0A,
        CRP_OP_COMPARE_SKIP = 5'h0B,
        CRP_OP_INCR_SKIP = 5'h0C,
        CRP_OP_INCR_MEM_SKIP = 5'h0D,
        CRP_OP_DECR_SKIP = 5'h0E,
        CRP_OP_DECR_MEM_SKIP = 5'h0F,
        CRP_OP_BTS0 = 5'h10,
        CRP_OP_BTS1 = 5'h11,
        CRP_OP_B0BTS0 = 5'h12,
        CRP_OP_B0BTS1 = 5'h13,
        CRP_OP_JMP = 5'h14,
        CRP_OP_CALL = 5'h15,
        CRP_OP_VECTOR = 5'h16,
        CRP_OP_SAVE = 5'h17,
        CRP_OP_RESTORE = 5'h18,
        CRP_OP_TABLE_FETCH = 5'h19,
        CRP_OP_MOV_REG_A = 5'h1A,
        CRP_OP_MOV_A_REG = 5'h1B,
        CRP_OP_BSET = 5'h1C,
        CRP_OP_BCLR = 5'h1D,
        CRP_OP_PCL_ADD = 5'h1E,
        CRP_OP_PCL_SUB = 5'h1F
    } crp_op_t;

    typedef struct packed {
        logic valid;
        crp_op_t code;
        logic carry_in;
        logic [7:0] operand;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [9:0] target;
    } crp_op_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crp_bus_req_t;

    typedef struct packed {
        logic [7:0] acc;
        logic flag_c;
        logic flag_dc;
        logic flag_z;
        logic [1:0] cause;
        logic [7:0] tbl_hi;
        logic [7:0] ptr_lo;
        logic [7:0] ptr_hi;
        logic [9:0] pc;
        logic [7:0] save_acc;
        logic [7:0] save_status;
        logic [7:0] rd_data;
        logic mem_we;
        logic [7:0] mem_wdata;
        logic hi_meta;
        logic hi_sync;
        logic mid_meta;
        logic mid_sync;
        logic hopt_meta;
        logic hopt_sync;
        logic mopt_meta;
        logic mopt_sync;
    } crp_state_t;

endpackage

// ==== core/crp_core.sv ====
// Notes on behaviour
// - Unmapped 8-bit work result register
// - Add/subtract update zero, carry, nibble flags; logic ops zero only, rotates carry only
// - Interrupt entry saves nothing but address
// - Save/restore copy result and flags buffers
// - Status bits 7:6 give reset cause
// - Bit 5 shows supply at/below high threshold
// - Bit 4 shows supply at/below mid threshold
// - Carry: add carry, no borrow, rotate-out
// - Nibble flag: low-nibble carry or no borrow
// - Zero flag set when result is zero
// - Ten-bit instruction pointer, reset to zero
// - Pointer advances one per instruction
// - Jump and call load full target address
// - Nine skip instructions advance pointer by two
// - Compare-skip skips when result register equals operand
// - Increment-skip skips on wrap to zero
// - Decrement-skip skips on one to zero
// - Add into low byte carries into high
// - Borrow from low byte leaves high unchanged
// - Two 8-bit pointer registers as storage
// - Pointer pair addresses table fetch ROM
// - Table fetch splits word into two registers
// - Bit set/clear only on read-write registers
`timescale 1ns/100ps
module crp_core
    import crp_pkg::*;
(
    // Clock and reset
    input logic core_clk,
    input logic rst,
    // Register port
    input crp_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // Instruction execution port
    input crp_op_req_t op_req,
    input logic [15:0] rom_word,
    // Supply monitor and reset controller
    input logic vdd_below_high,
    input logic vdd_below_mid,
    input logic brownout_high_option,
    input logic brownout_mid_option,
    input logic [1:0] reset_cause_in,
    // Datapath outputs
    output logic [7:0] work_result_reg,
    output logic [9:0] instr_addr,
    output logic [15:0] indirect_window,
    output logic [15:0] rom_addr,
    output logic mem_we,
    output logic [7:0] mem_wdata
);

    crp_state_t s_reg;
    crp_state_t s_next;

    // Readback of status, brownout bits are live and read-only
    function automatic logic [7:0] status_value(input crp_state_t st);
        logic [7:0] v;
        v = CRP_REG_RESET;
        v[CRP_CAUSE_HI] = st.cause[1];
        v[CRP_CAUSE_LO] = st.cause[0];
        v[CRP_FLAG_HIGH] = st.hi_sync & st.hopt_sync;
        v[CRP_FLAG_MID] = st.mid_sync & st.mopt_sync;
        v[CRP_FLAG_C] = st.flag_c;
        v[CRP_FLAG_DC] = st.flag_dc;
        v[CRP_FLAG_Z] = st.flag_z;
        return v;
    endfunction

    // Shared decode for bus reads and register moves
    function automatic logic [7:0] reg_read(input crp_state_t st, input logic [7:0] addr);
        logic [7:0] v;
        v = CRP_REG_RESET;
        case (addr)
            CRP_ADDR_TBL_HI: v = st.tbl_hi;
            CRP_ADDR_PTR_LO: v = st.ptr_lo;
            CRP_ADDR_PTR_HI: v = st.ptr_hi;
            CRP_ADDR_STATUS: v = status_value(st);
            CRP_ADDR_PC_LOW: v = st.pc[7:0];
            CRP_ADDR_PC_HIGH: v = {6'h00, st.pc[9:8]};
            default: v = CRP_REG_RESET;
        endcase
        return v;
    endfunction

    function automatic logic reg_is_rw(input logic [7:0] addr);
        logic ok;
        ok = 1'b0;
        case (addr)
            CRP_ADDR_TBL_HI, CRP_ADDR_PTR_LO, CRP_ADDR_PTR_HI,
            CRP_ADDR_STATUS, CRP_ADDR_PC_LOW, CRP_ADDR_PC_HIGH: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Write path shared by bus and instruction moves
    function automatic crp_state_t reg_write(input crp_state_t st, input logic [7:0] addr,
                                             input logic [7:0] data);
        crp_state_t r;
        r = st;
        case (addr)
            CRP_ADDR_TBL_HI: r.tbl_hi = data;
            CRP_ADDR_PTR_LO: r.ptr_lo = data;
            CRP_ADDR_PTR_HI: r.ptr_hi = data;

            CRP_ADDR_STATUS: begin
                r.cause = {data[CRP_CAUSE_HI], data[CRP_CAUSE_LO]};
                r.flag_c = data[CRP_FLAG_C];
                r.flag_dc = data[CRP_FLAG_DC];
                r.flag_z = data[CRP_FLAG_Z];
            end

            CRP_ADDR_PC_LOW: r.pc = {st.pc[9:8], data};
            CRP_ADDR_PC_HIGH: r.pc = {data[1:0], st.pc[7:0]};
            default: r = st;
        endcase
        return r;
    endfunction

    function automatic logic pc_touched(input logic [7:0] addr);
        return (addr == CRP_ADDR_PC_LOW) || (addr == CRP_ADDR_PC_HIGH);
    endfunction

    always_comb begin
        logic [8:0] sum9;
        logic [4:0] sum5;
        logic [7:0] res;
        logic [7:0] rv;
        logic cin;
        logic skip;
        logic pc_loaded;
        sum9 = 9'h000;
        sum5 = 5'h00;
        res = CRP_REG_RESET;
        rv = CRP_REG_RESET;
        cin = 1'b0;
        skip = 1'b0;
        pc_loaded = 1'b0;
        s_next = s_reg;
        // Strobe lasts one cycle only
        s_next.mem_we = 1'b0;

        // Two-stage synchronisers for analog and option levels
        // Brownout bits lag their inputs by two cycles
        s_next.hi_meta = vdd_below_high;
        s_next.hi_sync = s_reg.hi_meta;
        s_next.mid_meta = vdd_below_mid;
        s_next.mid_sync = s_reg.mid_meta;
        s_next.hopt_meta = brownout_high_option;
        s_next.hopt_sync = s_reg.hopt_meta;
        s_next.mopt_meta = brownout_mid_option;
        s_next.mopt_sync = s_reg.mopt_meta;

        // Read data valid only in the cycle after the strobe
        s_next.rd_data = bus_req.rd ? reg_read(s_reg, bus_req.addr) : CRP_REG_RESET;

        if (bus_req.wr) begin
            s_next = reg_write(s_next, bus_req.addr, bus_req.wdata);
            pc_loaded = pc_touched(bus_req.addr);
        end

        // Instruction results override a same-cycle bus write
        if (op_req.valid) begin
            case (op_req.code)
                CRP_OP_MOV_A_IMM: begin
                    s_next.acc = op_req.operand;
                end

                CRP_OP_ADD, CRP_OP_ADC, CRP_OP_SUB, CRP_OP_SBC: begin
                    cin = (op_req.code == CRP_OP_ADC || op_req.code == CRP_OP_SBC) ?
                          s_reg.flag_c : 1'b0;
                    rv = (op_req.code == CRP_OP_SUB || op_req.code == CRP_OP_SBC) ?
                         ~op_req.operand : op_req.operand;
                    if (op_req.code == CRP_OP_SUB) begin
                        cin = 1'b1;
                    end
                    sum9 = 9'({1'b0, s_reg.acc} + {1'b0, rv} + {8'h00, cin});
                    sum5 = 5'({1'b0, s_reg.acc[3:0]} + {1'b0, rv[3:0]} + {4'h0, cin});
                    s_next.acc = sum9[7:0];
                    s_next.flag_c = sum9[8];
                    s_next.flag_dc = sum5[4];
                    s_next.flag_z = (sum9[7:0] == CRP_REG_RESET);
                end

                CRP_OP_AND, CRP_OP_OR, CRP_OP_XOR: begin
                    case (op_req.code)
                        CRP_OP_AND: res = s_reg.acc & op_req.operand;
                        CRP_OP_OR: res = s_reg.acc | op_req.operand;
                        default: res = s_reg.acc ^ op_req.operand;
                    endcase
                    s_next.acc = res;
                    s_next.flag_z = (res == CRP_REG_RESET);
                end

                CRP_OP_RLC: begin
                    s_next.acc = {s_reg.acc[6:0], s_reg.flag_c};
                    s_next.flag_c = s_reg.acc[7];
                end

                CRP_OP_RRC: begin
                    s_next.acc = {s_reg.flag_c, s_reg.acc[7:1]};
                    s_next.flag_c = s_reg.acc[0];
                end

                CRP_OP_COMPARE_SKIP: begin
                    sum9 = 9'({1'b0, s_reg.acc} + {1'b0, ~op_req.operand} + 9'h001);
                    s_next.flag_c = sum9[8];
                    s_next.flag_z = (sum9[7:0] == CRP_REG_RESET);
                    skip = (s_reg.acc == op_req.operand);
                end

                CRP_OP_INCR_SKIP, CRP_OP_INCR_MEM_SKIP: begin
                    res = 8'(op_req.operand + CRP_ONE);
                    skip = (res == CRP_REG_RESET);
                    if (op_req.code == CRP_OP_INCR_SKIP) begin
                        s_next.acc = res;
                    end else begin
                        s_next.mem_we = 1'b1;
                        s_next.mem_wdata = res;
                    end
                end

                CRP_OP_DECR_SKIP, CRP_OP_DECR_MEM_SKIP: begin
                    res = 8'(op_req.operand - CRP_ONE);
                    skip = (op_req.operand == CRP_ONE);
                    if (op_req.code == CRP_OP_DECR_SKIP) begin
                        s_next.acc = res;
                    end else begin
                        s_next.mem_we = 1'b1;
                        s_next.mem_wdata = res;
                    end
                end

                CRP_OP_BTS0, CRP_OP_B0BTS0: begin
                    skip = ~op_req.operand[op_req.bit_sel];
                end

                CRP_OP_BTS1, CRP_OP_B0BTS1: begin
                    skip = op_req.operand[op_req.bit_sel];
                end

                CRP_OP_JMP, CRP_OP_CALL: begin
                    s_next.pc = op_req.target;
                    pc_loaded = 1'b1;
                end

                CRP_OP_VECTOR: begin
                    s_next.pc = op_req.target;
                    pc_loaded = 1'b1;
                end

                CRP_OP_SAVE: begin
                    s_next.save_acc = s_reg.acc;
                    s_next.save_status = status_value(s_reg);
                end

                CRP_OP_RESTORE: begin
                    s_next.acc = s_reg.save_acc;
                    s_next = reg_write(s_next, CRP_ADDR_STATUS, s_reg.save_status);
                end

                CRP_OP_TABLE_FETCH: begin
                    // high to table register, low to result
                    s_next.tbl_hi = rom_word[15:8];
                    s_next.acc = rom_word[7:0];
                end

                CRP_OP_MOV_REG_A: begin
                    // Pc targets count as loads, no extra step
                    s_next = reg_write(s_next, op_req.addr, s_reg.acc);
                    pc_loaded = pc_loaded | pc_touched(op_req.addr);
                end

                CRP_OP_MOV_A_REG: begin
                    // Same decode as bus reads
                    s_next.acc = reg_read(s_reg, op_req.addr);
                end

                CRP_OP_BSET, CRP_OP_BCLR: begin
                    if (reg_is_rw(op_req.addr)) begin
                        rv = reg_read(s_reg, op_req.addr);
                        rv[op_req.bit_sel] = (op_req.code == CRP_OP_BSET);
                        s_next = reg_write(s_next, op_req.addr, rv);
                        pc_loaded = pc_loaded | pc_touched(op_req.addr);
                    end
                end

                CRP_OP_PCL_ADD: begin
                    cin = op_req.carry_in & s_reg.flag_c;
                    sum9 = 9'({1'b0, s_reg.pc[7:0]} + {1'b0, s_reg.acc} + {8'h00, cin});
                    sum5 = 5'({1'b0, s_reg.pc[3:0]} + {1'b0, s_reg.acc[3:0]} + {4'h0, cin});
                    s_next.pc = {2'(s_reg.pc[9:8] + {1'b0, sum9[8]}), sum9[7:0]};
                    s_next.flag_c = sum9[8];
                    s_next.flag_dc = sum5[4];
                    s_next.flag_z = (sum9[7:0] == CRP_REG_RESET);
                    pc_loaded = 1'b1;
                end

                CRP_OP_PCL_SUB: begin
                    sum9 = 9'({1'b0, s_reg.pc[7:0]} + {1'b0, ~s_reg.acc} + 9'h001);
                    sum5 = 5'({1'b0, s_reg.pc[3:0]} + {1'b0, ~s_reg.acc[3:0]} + 5'h01);
                    s_next.pc = {s_reg.pc[9:8], sum9[7:0]};
                    s_next.flag_c = sum9[8];
                    s_next.flag_dc = sum5[4];
                    s_next.flag_z = (sum9[7:0] == CRP_REG_RESET);
                    pc_loaded = 1'b1;
                end

                default: begin
                    s_next.acc = s_reg.acc;
                end
            endcase
            // two steps on a true skip
            if (!pc_loaded) begin
                s_next.pc = 10'(s_reg.pc + (skip ? CRP_PC_SKIP : CRP_PC_STEP));
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.pc <= CRP_PC_RESET;
            s_reg.cause <= reset_cause_in;

        end else begin
            s_reg <= s_next;
        end
    end

    assign bus_rdata = s_reg.rd_data;
    // result register only on a port
    assign work_result_reg = s_reg.acc;
    assign instr_addr = s_reg.pc;
    assign indirect_window = {s_reg.ptr_hi, s_reg.ptr_lo};
    assign rom_addr = {s_reg.ptr_hi, s_reg.ptr_lo};
    assign mem_we = s_reg.mem_we;
    assign mem_wdata = s_reg.mem_wdata;

endmodule

// ==== sim/crp_core_checker.sv ====
`timescale 1ns/100ps
module crp_core_checker
    import crp_pkg::*;
(
    // Clock and reset
    input logic core_clk,
    input logic rst,
    // Register and op ports
    input crp_bus_req_t bus_req,
    input crp_op_req_t op_req,
    input logic [15:0] rom_word,
    // Datapath outputs
    input logic [7:0] work_result_reg,
    input logic [9:0] instr_addr,
    input logic [15:0] indirect_window,
    input logic [15:0] rom_addr,
    input logic mem_we,
    input logic [7:0] mem_wdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Bus writes may also move pc, so op checks leave them out
    logic go;
    logic solo_wr;
    assign go = op_req.valid && !bus_req.wr;
    assign solo_wr = bus_req.wr && !op_req.valid;

    chk_reset_clear: assert property (
        $fell(rst) |-> instr_addr == CRP_PC_RESET && work_result_reg == CRP_REG_RESET)
        else $error("pc or result not clear after reset");
    chk_pc_step: assert property (
        go && op_req.code == CRP_OP_NOP |=> instr_addr == $past(instr_addr) + CRP_PC_STEP)
        else $error("pc did not advance by one");
    chk_jump_load: assert property (
        go && (op_req.code == CRP_OP_JMP || op_req.code == CRP_OP_CALL)
        |=> instr_addr == $past(op_req.target))
        else $error("jump target not loaded");
    chk_vector_keep: assert property (
        go && op_req.code == CRP_OP_VECTOR
        |=> $stable(work_result_reg) && instr_addr == $past(op_req.target))
        else $error("interrupt entry touched result");
    chk_cmp_skip: assert property (
        go && op_req.code == CRP_OP_COMPARE_SKIP && op_req.operand == work_result_reg
        |=> instr_addr == $past(instr_addr) + CRP_PC_SKIP && $stable(work_result_reg))
        else $error("compare equal did not skip");
    chk_incr_wrap: assert property (
        go && op_req.code == CRP_OP_INCR_MEM_SKIP && op_req.operand == 8'hFF
        |=> mem_we && mem_wdata == 8'h00 && instr_addr == $past(instr_addr) + CRP_PC_SKIP)
        else $error("increment wrap did not skip");
    chk_decr_zero: assert property (
        go && op_req.code == CRP_OP_DECR_MEM_SKIP && op_req.operand == 8'h01
        |=> mem_we && mem_wdata == 8'h00 && instr_addr == $past(instr_addr) + CRP_PC_SKIP)
        else $error("decrement to zero did not skip");
    chk_pcl_carry: assert property (
        go && op_req.code == CRP_OP_PCL_ADD && !op_req.carry_in
        |=> instr_addr == $past(instr_addr) + {2'h0, $past(work_result_reg)})
        else $error("low byte carry lost");
    chk_pcl_borrow: assert property (
        go && op_req.code == CRP_OP_PCL_SUB |=> instr_addr[9:8] == $past(instr_addr[9:8])
        && instr_addr[7:0] == $past(instr_addr[7:0]) - $past(work_result_reg))
        else $error("low byte borrow moved high byte");
    chk_fetch_low: assert property (
        go && op_req.code == CRP_OP_TABLE_FETCH |=> work_result_reg == $past(rom_word[7:0]))
        else $error("table fetch low byte wrong");
    chk_ptr_high: assert property (
        solo_wr && bus_req.addr == CRP_ADDR_PTR_HI |=> indirect_window[15:8] ==
        $past(bus_req.wdata) && rom_addr[15:8] == $past(bus_req.wdata))
        else $error("pointer high part wrong");
    chk_pcl_page: assert property (
        solo_wr && bus_req.addr == CRP_ADDR_PC_LOW
        |=> instr_addr == {$past(instr_addr[9:8]), $past(bus_req.wdata)})
        else $error("low byte write left page");

    cov_fetch: cover property (go && op_req.code == CRP_OP_TABLE_FETCH);
    cov_mem_skip: cover property (mem_we);
    cov_pcl_add: cover property (go && op_req.code == CRP_OP_PCL_ADD);
endmodule

bind crp_core crp_core_checker chk_inst (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .op_req(op_req), .rom_word(rom_word), .work_result_reg(work_result_reg),
    .instr_addr(instr_addr), .indirect_window(indirect_window), .rom_addr(rom_addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata));

// ==== sim/cpu_core_regs_pc_flags_tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module cpu_core_regs_pc_flags_tb;
    import crp_pkg::*;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    crp_bus_req_t bus_req = '0;
    crp_op_req_t op_req = '0;
    logic [15:0] rom_word = 16'hBEEF;
    logic vdd_hi = 1'h0;
    logic vdd_mid = 1'h0;
    logic opt_hi = 1'h0;
    logic opt_mid = 1'h0;
    logic [1:0] cause = 2'h3;
    logic [7:0] bus_rdata;
    logic [7:0] work_result_reg;
    logic [9:0] instr_addr;
    logic [15:0] indirect_window;
    logic [15:0] rom_addr;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [9:0] exp_pc;
    int bad_count = 0;
    int n_checks = 0;

    always #10 core_clk = ~core_clk;

    crp_core uut (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .op_req(op_req), .rom_word(rom_word), .vdd_below_high(vdd_hi),
        .vdd_below_mid(vdd_mid), .brownout_high_option(opt_hi),
        .brownout_mid_option(opt_mid), .reset_cause_in(cause),
        .work_result_reg(work_result_reg), .instr_addr(instr_addr),
        .indirect_window(indirect_window), .rom_addr(rom_addr), .mem_we(mem_we),
        .mem_wdata(mem_wdata));

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge core_clk);
        bus_req.wr <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        bus_req.rd <= 1'h0;
        #1;
        `CHK("read data", e, bus_rdata)
    endtask

    // Target doubles as the expected next pc
    task automatic op(input crp_op_t c, input logic [7:0] v, input logic [9:0] nxt);
        @(posedge core_clk);
        op_req <= '{valid: 1'h1, code: c, carry_in: 1'h0, operand: v, addr: v,
            bit_sel: 3'h3, target: nxt};
        @(posedge core_clk);
        op_req.valid <= 1'h0;
        #1;
        exp_pc = nxt;
        `CHK("pc", exp_pc, instr_addr)
    endtask

    task automatic t_reset();
        for (logic [2:0] i = 3'h0; i < 3'h4; i++) begin
            @(posedge core_clk);
            rst <= 1'h1;
            cause <= i[1:0];
            repeat (16) @(posedge core_clk);
            rst <= 1'h0;
            #1;
            exp_pc = CRP_PC_RESET;
            `CHK("pc after reset", exp_pc, instr_addr)
            `CHK("result after reset", 8'h00, work_result_reg)
            rd(CRP_ADDR_STATUS, {i[1:0], 6'h00});
        end
    endtask

    task automatic t_alu();
        crp_op_t cs[9] = '{CRP_OP_ADD, CRP_OP_ADD, CRP_OP_SUB, CRP_OP_SUB, CRP_OP_AND,
            CRP_OP_XOR, CRP_OP_OR, CRP_OP_RLC, CRP_OP_RRC};
        logic [7:0] a[9] = '{8'h0F, 8'h10, 8'h10, 8'h01, 8'hF0, 8'h55, 8'h50, 8'h80, 8'h01};
        logic [7:0] b[9] = '{8'h01, 8'hF0, 8'h01, 8'h02, 8'h0F, 8'h55, 8'h05, 8'h80, 8'h01};
        logic [7:0] r[9] = '{8'h10, 8'h00, 8'h0F, 8'hFF, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00};
        logic [2:0] f[9] = '{3'h2, 3'h5, 3'h4, 3'h0, 3'h1, 3'h1, 3'h0, 3'h4, 3'h4};
        for (int k = 0; k < 9; k++) begin
            wr(CRP_ADDR_STATUS, 8'hC0);
            op(CRP_OP_MOV_A_IMM, a[k], exp_pc + CRP_PC_STEP);
            op(cs[k], b[k], exp_pc + CRP_PC_STEP);
            `CHK("alu result", r[k], work_result_reg)
            rd(CRP_ADDR_STATUS, {5'h18, f[k]});
        end
        wr(CRP_ADDR_STATUS, 8'hC4);
        op(CRP_OP_MOV_A_IMM, 8'h0F, exp_pc + CRP_PC_STEP);
        op(CRP_OP_ADC, 8'h00, exp_pc + CRP_PC_STEP);
        `CHK("add with carry", 8'h10, work_result_reg)
        rd(CRP_ADDR_STATUS, 8'hC2);
        wr(CRP_ADDR_STATUS, 8'hC0);
        op(CRP_OP_MOV_A_IMM, 8'h10, exp_pc + CRP_PC_STEP);
        op(CRP_OP_SBC, 8'h01, exp_pc + CRP_PC_STEP);
        `CHK("sub with borrow", 8'h0E, work_result_reg)
        rd(CRP_ADDR_STATUS, 8'hC4);
    endtask

    task automatic t_save();
        wr(CRP_ADDR_STATUS, 8'hC5);
        op(CRP_OP_MOV_A_IMM, 8'h5A, exp_pc + CRP_PC_STEP);
        op(CRP_OP_SAVE, 8'h00, exp_pc + CRP_PC_STEP);
        op(CRP_OP_VECTOR, 8'h00, 10'h008);
        `CHK("result on entry", 8'h5A, work_result_reg)
        rd(CRP_ADDR_STATUS, 8'hC5);
        wr(CRP_ADDR_STATUS, 8'h02);
        op(CRP_OP_MOV_A_IMM, 8'h00, exp_pc + CRP_PC_STEP);
        op(CRP_OP_RESTORE, 8'h00, exp_pc + CRP_PC_STEP);
        `CHK("result restored", 8'h5A, work_result_reg)
        rd(CRP_ADDR_STATUS, 8'hC5);
    endtask

    task automatic t_skip();
        crp_op_t sc[13] = '{CRP_OP_COMPARE_SKIP, CRP_OP_COMPARE_SKIP, CRP_OP_INCR_SKIP,
            CRP_OP_INCR_SKIP, CRP_OP_INCR_MEM_SKIP, CRP_OP_DECR_SKIP, CRP_OP_DECR_SKIP,
            CRP_OP_DECR_MEM_SKIP, CRP_OP_BTS0, CRP_OP_BTS1, CRP_OP_BTS1, CRP_OP_B0BTS0,
            CRP_OP_B0BTS1};
        logic [7:0] so[13] = '{8'h12, 8'h13, 8'hFF, 8'h05, 8'hFF, 8'h01, 8'h02, 8'h01,
            8'h00, 8'h08, 8'h00, 8'h08, 8'h08};
        logic [12:0] sk = 13'h13B5;
        logic [7:0] md;
        for (int k = 0; k < 13; k++) begin
            op(CRP_OP_MOV_A_IMM, 8'h12, exp_pc + CRP_PC_STEP);
            op(sc[k], so[k], exp_pc + (sk[k] ? CRP_PC_SKIP : CRP_PC_STEP));
            md = (sc[k] == CRP_OP_INCR_MEM_SKIP) ? so[k] + 8'h01 : so[k] - 8'h01;
            if (sc[k] == CRP_OP_INCR_MEM_SKIP || sc[k] == CRP_OP_DECR_MEM_SKIP) begin
                `CHK("mem strobe", 1'h1, mem_we)
                `CHK("mem data", md, mem_wdata)
            end
        end
    endtask

    task automatic t_pc();
        op(CRP_OP_JMP, 8'h00, 10'h3FF);
        op(CRP_OP_NOP, 8'h00, 10'h000);
        op(CRP_OP_CALL, 8'h00, 10'h1F0);
        op(CRP_OP_MOV_A_IMM, 8'h20, 10'h1F1);
        op(CRP_OP_PCL_ADD, 8'h20, 10'h211);
        op(CRP_OP_PCL_SUB, 8'h20, 10'h2F1);
        wr(CRP_ADDR_PC_LOW, 8'h28);
        `CHK("pc low write", 10'h228, instr_addr)
        wr(CRP_ADDR_PC_HIGH, 8'h01);
        exp_pc = 10'h128;
        `CHK("pc high write", exp_pc, instr_addr)
    endtask

    task automatic t_regs();
        wr(CRP_ADDR_PTR_HI, 8'h12);
        wr(CRP_ADDR_PTR_LO, 8'h34);
        `CHK("indirect", 16'h1234, indirect_window)
        `CHK("rom addr", 16'h1234, rom_addr)
        rd(CRP_ADDR_PTR_LO, 8'h34);
        rd(CRP_ADDR_PTR_HI, 8'h12);
        op(CRP_OP_TABLE_FETCH, 8'h00, exp_pc + CRP_PC_STEP);
        `CHK("fetch low", 8'hEF, work_result_reg)
        rd(CRP_ADDR_TBL_HI, 8'hBE);
        op(CRP_OP_BCLR, CRP_ADDR_TBL_HI, exp_pc + CRP_PC_STEP);
        rd(CRP_ADDR_TBL_HI, 8'hB6);
        op(CRP_OP_BSET, 8'h85, exp_pc + CRP_PC_STEP);
        wr(8'h85, 8'hFF);
        rd(8'h85, 8'h00);
        op(CRP_OP_MOV_REG_A, CRP_ADDR_PTR_LO, exp_pc + CRP_PC_STEP);
        rd(CRP_ADDR_PTR_LO, 8'hEF);
        op(CRP_OP_MOV_A_REG, CRP_ADDR_PTR_HI, exp_pc + CRP_PC_STEP);
        `CHK("move to result", 8'h12, work_result_reg)
    endtask

    // Flags pass a two-stage synchroniser, so allow settling
    task automatic t_brown();
        wr(CRP_ADDR_STATUS, 8'hC0);
        @(posedge core_clk);
        vdd_hi <= 1'h1;
        opt_hi <= 1'h1;
        vdd_mid <= 1'h1;
        repeat (3) @(posedge core_clk);
        rd(CRP_ADDR_STATUS, 8'hE0);
        @(posedge core_clk);
        opt_mid <= 1'h1;
        repeat (3) @(posedge core_clk);
        rd(CRP_ADDR_STATUS, 8'hF0);
        wr(CRP_ADDR_STATUS, 8'h08);
        rd(CRP_ADDR_STATUS, 8'h30);
        @(posedge core_clk);
        vdd_hi <= 1'h0;
        vdd_mid <= 1'h0;
        repeat (3) @(posedge core_clk);
        rd(CRP_ADDR_STATUS, 8'h00);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        close_out();
    end

    initial begin
        t_reset();
        t_alu();
        t_save();
        t_skip();
        t_pc();
        t_regs();
        t_brown();
        close_out();
    end
endmodule
